// >>> taq_cfg.svh
// Purpose: Constants for the temperature alert qualify and beta register bank.
// Assumes: Byte-wide register port inside the device, 125 MHz mclk.
// Notes: Offsets are register addresses on the management bus.
// Summary of operation
// - Fault register names faulted external diode.
// - Reading fault register returns then clears.
// - Bits 3..1 flag diodes 3..1.
// - Masked channel never drives alert; thermal unmasked.
// - Voltage and peak masks block alert.
// - Diode masks block limit and fault alerts.
// - Internal mask blocks internal limit alerts.
// - Count settings apply to temperature and diode fault queues only.
// - Comparator mode counts only high-limit and crit hits.
// - Separate high, low, fault queues per diode.
// - Timeout bit enables 30ms clock-low reset.
// - Bits 6-4 set thermal consecutive count.
// - Bits 3-1 set alert consecutive count.
// - Codes 000,001,011,111 mean 1..4.
// - Consecutive register resets to 70h.
// - Autodetect applies and shows detected beta.
// - Manual beta code selects compensation; 1111 off.
// - Beta code writes ignored while autodetect on.
`ifndef TAQ_CFG_SVH
`define TAQ_CFG_SVH
`define TAQ_ADDR_FAULT 8'h1B
`define TAQ_ADDR_MASK 8'h1F
`define TAQ_ADDR_CONSEC 8'h22
`define TAQ_ADDR_BETA1 8'h25
`define TAQ_ADDR_BETA2 8'h26
`define TAQ_RST_FAULT 8'h00
`define TAQ_RST_MASK 8'h00
`define TAQ_RST_CONSEC 8'h70
`define TAQ_RST_BETA 8'h10
`define TAQ_BIT_TIMEOUT 7
`define TAQ_BIT_AUTO 4
`define TAQ_BIT_VSENSE 7
`define TAQ_BIT_VSRC 6
`define TAQ_BIT_PEAK 5
`define TAQ_FAULT_MASK 8'h0E
`define TAQ_CONSEC_MASK 8'hFE
`define TAQ_BETA_MASK 8'h1F
`define TAQ_BETA_OFF 4'hF
`define TAQ_BETA_MSB 3
`define TAQ_ALERT_MSB 3
`define TAQ_ALERT_LSB 1
`define TAQ_CRIT_MSB 6
`define TAQ_CRIT_LSB 4
`define TAQ_TIMEOUT_MS 30
`define TAQ_CLK_MHZ 125
`define TAQ_TIMEOUT_CYC (`TAQ_TIMEOUT_MS * 1000 * `TAQ_CLK_MHZ)
`endif

// >>> taq_host_model.sv
// Purpose: Host model that reads and writes the register port.
// Assumes: One access at a time, launched 1 ns after mclk rises.
// Notes: Address and data are inverted once released, so the block cannot use stale values.
`timescale 1ns/1ps
module taq_host_model (
    // Clock
    input wire logic mclk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit
);
    logic last_hit = 1'b0;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk) #1;
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge mclk) #1;
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk) #1;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge mclk);
        last_hit = reg_hit;
        #1;
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
    // Autodetect is cleared first, as code bits are ignored while it is on.
    // Diode 3 has no beta register at all.
    task automatic manual_beta(input logic [7:0] a, input logic [3:0] code);
        wr(a, 8'h00);
        wr(a, {4'h0, code});
    endtask
endmodule

// >>> taq_pkg.sv
// Purpose: Types for the alert qualify register bank.
// Assumes: Nothing beyond the constants header.
// Notes: Holds the bus timeout monitor states.
package taq_pkg;
    typedef enum logic [1:0] {
        TAQ_TO_IDLE = 2'b01,
        TAQ_TO_LOW = 2'b10
    } taq_to_e;
    typedef logic [2:0] taq_cnt_t;
endpackage

// >>> taq_regs.sv
// Purpose: Fault flags, alert masking, consecutive queues and beta config registers.
// Assumes: Single-cycle byte register port from the bus protocol engine.
// Notes: Alert and thermal outputs are active low and come from flip-flops.
`timescale 1ns/1ps
`include "taq_cfg.svh"
module taq_regs
    import taq_pkg::*;
#(
    parameter int TIMEOUT_CYC = `TAQ_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Measurement results, one pulse per conversion, bit 0 is internal, bit n (1..3) is external diode n
    input wire logic conv_done,
    input wire logic [3:1] diode_fault,
    input wire logic [3:0] temp_high,
    input wire logic [3:0] temp_low,
    input wire logic [3:0] temp_crit,
    input wire logic alert_comparator_mode,
    // Voltage and peak alert sources, qualified elsewhere
    input wire logic vsense_alert,
    input wire logic vsource_alert,
    input wire logic peak_alert,
    // Beta autodetect interface
    input wire logic [3:0] beta_detected_1,
    input wire logic [3:0] beta_detected_2,
    output logic [3:0] beta_comp_code_1,
    output logic [3:0] beta_comp_code_2,
    output logic beta_autodetect_en_1,
    output logic beta_autodetect_en_2,
    // Pins
    input wire logic bus_clock_line,
    output logic bus_timeout_rst,
    output logic alert_out_n,
    output logic thermal_out_n
);
    localparam int CW = 32;
    localparam logic [CW-1:0] TO_LIMIT = CW'(TIMEOUT_CYC);

    logic rst_s1_ff, rst_n_ff;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_n_ff <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n_ff <= rst_s1_ff;
        end
    end

    logic scl_s1_ff, scl_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            scl_s1_ff <= 1'b1;
            scl_ff <= 1'b1;
        end else if (clk_en) begin
            scl_s1_ff <= bus_clock_line;
            scl_ff <= scl_s1_ff;
        end
    end

    logic [7:0] fault_ff, mask_ff, consec_ff, beta1_ff, beta2_ff;
    wire sel_fault = reg_addr == `TAQ_ADDR_FAULT;
    wire sel_mask = reg_addr == `TAQ_ADDR_MASK;
    wire sel_consec = reg_addr == `TAQ_ADDR_CONSEC;
    wire sel_beta1 = reg_addr == `TAQ_ADDR_BETA1;
    wire sel_beta2 = reg_addr == `TAQ_ADDR_BETA2;
    assign reg_hit = sel_fault | sel_mask | sel_consec | sel_beta1 | sel_beta2;

    wire [7:0] fault_set = {4'h0, conv_done ? diode_fault : 3'b000, 1'b0};
    // The set term wins over the read clear so a fault in the read cycle survives.
    wire fault_rd = clk_en & reg_rd & sel_fault;
    wire [7:0] nxt_fault = ((fault_rd ? 8'h00 : fault_ff) | fault_set) & `TAQ_FAULT_MASK;

    // Beta field tracks detection when autodetect is on; writes then only touch bit 4.
    function automatic logic [7:0] beta_next(input logic [7:0] cur, input logic wr,
                                             input logic [7:0] wd, input logic [3:0] det,
                                             input logic conv);
        logic [7:0] v;
        v = cur;
        if (wr) begin
            v[`TAQ_BIT_AUTO] = wd[`TAQ_BIT_AUTO];
            if (!cur[`TAQ_BIT_AUTO]) begin
                v[3:0] = wd[3:0];
            end
        end
        if (cur[`TAQ_BIT_AUTO] && conv) begin
            v[3:0] = det;
        end
        beta_next = v & `TAQ_BETA_MASK;
    endfunction

    wire wr_ok = clk_en & reg_wr;
    wire [7:0] nxt_beta1 = beta_next(beta1_ff, wr_ok & sel_beta1, reg_wdata, beta_detected_1,
                                     conv_done);
    wire [7:0] nxt_beta2 = beta_next(beta2_ff, wr_ok & sel_beta2, reg_wdata, beta_detected_2,
                                     conv_done);

    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            fault_ff <= `TAQ_RST_FAULT;
            mask_ff <= `TAQ_RST_MASK;
            consec_ff <= `TAQ_RST_CONSEC;
            beta1_ff <= `TAQ_RST_BETA;
            beta2_ff <= `TAQ_RST_BETA;
        end else if (clk_en) begin
            fault_ff <= nxt_fault;
            if (reg_wr && sel_mask) begin
                mask_ff <= reg_wdata;
            end
            if (reg_wr && sel_consec) begin
                consec_ff <= reg_wdata & `TAQ_CONSEC_MASK;
            end
            beta1_ff <= nxt_beta1;
            beta2_ff <= nxt_beta2;
        end
    end

    wire [7:0] rd_mux = sel_fault ? fault_ff :
                        sel_mask ? mask_ff :
                        sel_consec ? consec_ff :
                        sel_beta1 ? beta1_ff :
                        sel_beta2 ? beta2_ff : 8'h00;
    logic [7:0] rdata_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            rdata_ff <= 8'h00;
        end else if (clk_en && reg_rd) begin
            rdata_ff <= rd_mux;
        end
    end
    assign reg_rdata = rdata_ff;

    assign beta_comp_code_1 = beta1_ff[`TAQ_BETA_MSB:0];
    assign beta_comp_code_2 = beta2_ff[`TAQ_BETA_MSB:0];
    assign beta_autodetect_en_1 = beta1_ff[`TAQ_BIT_AUTO];
    assign beta_autodetect_en_2 = beta2_ff[`TAQ_BIT_AUTO];

    // Thermometer codes: count of ones plus one gives the needed number.
    function automatic taq_cnt_t decode_cnt(input logic [2:0] c);
        decode_cnt = 3'(c[0]) + 3'(c[1]) + 3'(c[2]) + 3'h1;
    endfunction
    wire taq_cnt_t alert_need = decode_cnt(consec_ff[`TAQ_ALERT_MSB:`TAQ_ALERT_LSB]);
    wire taq_cnt_t crit_need = decode_cnt(consec_ff[`TAQ_CRIT_MSB:`TAQ_CRIT_LSB]);

    // Queue index 0..3 is internal, diode 1..3; internal keeps only high and crit.
    logic [3:0] hi_q, lo_q, flt_q, crit_q;
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_chan
            logic [2:0] hi_ff, lo_ff, flt_ff, cr_ff;
            wire hi_ev = temp_high[g];
            wire lo_ev = temp_low[g] & ~alert_comparator_mode;
            wire flt_ev = (g != 0) && diode_fault[(g == 0) ? 1 : g] && !alert_comparator_mode;
            always_ff @(posedge mclk or negedge rst_n_ff) begin
                if (!rst_n_ff) begin
                    hi_ff <= 3'h0;
                    lo_ff <= 3'h0;
                    flt_ff <= 3'h0;
                    cr_ff <= 3'h0;
                end else if (clk_en && conv_done) begin
                    hi_ff <= hi_ev ? (hi_ff == alert_need ? hi_ff : hi_ff + 3'h1) : 3'h0;
                    lo_ff <= lo_ev ? (lo_ff == alert_need ? lo_ff : lo_ff + 3'h1) : 3'h0;
                    flt_ff <= flt_ev ? (flt_ff == alert_need ? flt_ff : flt_ff + 3'h1) : 3'h0;
                    cr_ff <= temp_crit[g] ? (cr_ff == crit_need ? cr_ff : cr_ff + 3'h1) : 3'h0;
                end
            end
            assign hi_q[g] = hi_ff >= alert_need;
            assign lo_q[g] = (g != 0) && (lo_ff >= alert_need);
            assign flt_q[g] = (g != 0) && (flt_ff >= alert_need);
            assign crit_q[g] = cr_ff >= crit_need;
        end
    endgenerate

    // Voltage and peak sources arrive already qualified by their own settings.
    wire [7:0] alert_src = {vsense_alert, vsource_alert, peak_alert, 1'b0,
                            hi_q | lo_q | flt_q};
    wire [7:0] alert_eff = alert_src & ~mask_ff;
    logic alert_ff, thermal_out_n_ff;
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            alert_ff <= 1'b1;
            thermal_out_n_ff <= 1'b1;
        end else if (clk_en) begin
            alert_ff <= ~|alert_eff;
            thermal_out_n_ff <= ~|crit_q;
        end
    end
    assign alert_out_n = alert_ff;
    assign thermal_out_n = thermal_out_n_ff;

    // Bus clock low timeout monitor.
    taq_to_e to_st_ff;
    logic [CW-1:0] to_cnt_ff;
    logic to_rst_ff;
    wire to_en = consec_ff[`TAQ_BIT_TIMEOUT];
    always_ff @(posedge mclk or negedge rst_n_ff) begin
        if (!rst_n_ff) begin
            to_st_ff <= TAQ_TO_IDLE;
            to_cnt_ff <= '0;
            to_rst_ff <= 1'b0;
        end else if (clk_en) begin
            to_rst_ff <= 1'b0;
            case (to_st_ff)
                TAQ_TO_IDLE: begin
                    to_cnt_ff <= '0;
                    if (to_en && !scl_ff) begin
                        to_st_ff <= TAQ_TO_LOW;
                    end
                end
                TAQ_TO_LOW: begin
                    if (!to_en || scl_ff) begin
                        to_st_ff <= TAQ_TO_IDLE;
                    end else if (to_cnt_ff >= TO_LIMIT) begin
                        to_rst_ff <= 1'b1;
                        to_st_ff <= TAQ_TO_IDLE;
                    end else begin
                        to_cnt_ff <= to_cnt_ff + 32'h1;
                    end
                end
                default: to_st_ff <= TAQ_TO_IDLE;
            endcase
        end
    end
    assign bus_timeout_rst = to_rst_ff;

    a_fault_rd_clr: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && reg_rd && sel_fault && !conv_done) |=> fault_ff == 8'h00)
        else $error("fault register not cleared by read");
    a_fault_sticky: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && fault_ff[1] && !fault_rd) |=> fault_ff[1])
        else $error("fault flag dropped without read");
    a_beta_hold: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (beta1_ff[4] && !conv_done) |=> $stable(beta1_ff[3:0]))
        else $error("beta changed by write while autodetect on");
    a_beta_track: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && beta1_ff[4] && conv_done) |=> beta1_ff[3:0] == $past(beta_detected_1))
        else $error("beta did not follow detection");
    a_mask_alert: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && &mask_ff[7:5] && &mask_ff[3:0]) |=> alert_out_n)
        else $error("masked channels asserted alert");
    a_thermal_out_n_unmask: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && |crit_q) |=> !thermal_out_n)
        else $error("thermal not asserted on qualified crit");
    a_consec_rsvd: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        consec_ff[0] == 1'b0)
        else $error("reserved consecutive bit set");
    a_timeout_off: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        !consec_ff[`TAQ_BIT_TIMEOUT] |=> !bus_timeout_rst)
        else $error("timeout fired while disabled");

    // Named steps used below; each is a register transfer or a conversion that the block has taken.
    // Keeping them apart from the properties lets one step serve several checks.
    sequence s_read_fault;
        clk_en && reg_rd && sel_fault;
    endsequence
    sequence s_write_mask;
        clk_en && reg_wr && sel_mask;
    endsequence
    sequence s_write_consec;
        clk_en && reg_wr && sel_consec;
    endsequence
    sequence s_conv_comp;
        clk_en && conv_done && alert_comparator_mode;
    endsequence

    // Register checks.
    a_fault_rd_data: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        s_read_fault |=> reg_rdata == $past(fault_ff))
        else $error("fault read returned wrong data");
    a_rdata_hold: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        !(clk_en && reg_rd) |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_mask_write: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        s_write_mask |=> mask_ff == $past(reg_wdata))
        else $error("mask write not taken");
    a_consec_write: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        s_write_consec |=> consec_ff == ($past(reg_wdata) & `TAQ_CONSEC_MASK))
        else $error("consecutive write not taken");
    a_fault_unused: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (fault_ff & ~`TAQ_FAULT_MASK) == 8'h00)
        else $error("unused fault bit set");
    a_fault_set: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && conv_done && diode_fault[1]) |=> fault_ff[1])
        else $error("diode fault not flagged");
    a_beta_manual: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && reg_wr && sel_beta1 && !beta1_ff[`TAQ_BIT_AUTO])
        |=> beta1_ff[3:0] == $past(reg_wdata[3:0]))
        else $error("manual beta write not taken");
    a_beta_unused: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        ((beta1_ff | beta2_ff) & ~`TAQ_BETA_MASK) == 8'h00)
        else $error("unused beta bit set");
    a_beta2_hold: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (beta2_ff[4] && !conv_done) |=> $stable(beta2_ff[3:0]))
        else $error("beta 2 changed by write while autodetect on");
    a_beta2_track: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && beta2_ff[4] && conv_done) |=> beta2_ff[3:0] == $past(beta_detected_2))
        else $error("beta 2 did not follow detection");

    // Queue checks; counters only move on a conversion.
    a_need_range: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        alert_need != 3'h0 && crit_need != 3'h0 && alert_need <= 3'h4 && crit_need <= 3'h4)
        else $error("decoded count out of range");
    a_need_three: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        consec_ff[3:1] == 3'b011 |-> alert_need == 3'h3)
        else $error("code 011 not decoded as three");
    a_comp_queues: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        s_conv_comp |=> g_chan[1].lo_ff == 3'h0 && g_chan[2].flt_ff == 3'h0)
        else $error("low or fault queue counted in comparator mode");
    a_low_count: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && conv_done && !alert_comparator_mode && temp_low[3])
        |=> g_chan[3].lo_ff != 3'h0)
        else $error("low queue did not count");
    a_int_no_low: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        lo_q[0] == 1'b0 && flt_q[0] == 1'b0)
        else $error("internal channel has low or fault queue");
    a_crit_clear: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && conv_done && !temp_crit[2]) |=> g_chan[2].cr_ff == 3'h0)
        else $error("crit queue not cleared");

    // Pin checks.
    a_alert_diode: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && hi_q[1] && !mask_ff[1]) |=> !alert_out_n)
        else $error("unmasked diode high did not alert");
    a_alert_fault: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && flt_q[2] && !mask_ff[2]) |=> !alert_out_n)
        else $error("unmasked diode fault did not alert");
    a_alert_int: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && hi_q[0] && !mask_ff[0]) |=> !alert_out_n)
        else $error("unmasked internal high did not alert");
    a_alert_vsense: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && vsense_alert && !mask_ff[`TAQ_BIT_VSENSE]) |=> !alert_out_n)
        else $error("unmasked sense voltage did not alert");
    a_vmask_block: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && &mask_ff[`TAQ_BIT_VSENSE:`TAQ_BIT_PEAK] && (hi_q | lo_q | flt_q) == 4'h0)
        |=> alert_out_n)
        else $error("masked voltage source asserted alert");
    a_thermal_out_n_idle: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && crit_q == 4'h0) |=> thermal_out_n)
        else $error("thermal asserted without qualified crit");
    a_timeout_pulse: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        (clk_en && bus_timeout_rst) |=> !bus_timeout_rst)
        else $error("timeout reset longer than one cycle");
    a_timeout_low: assert property (@(posedge mclk) disable iff (!rst_n_ff)
        bus_timeout_rst |-> !$past(scl_ff))
        else $error("timeout fired with clock line high");
endmodule

// >>> tb_top.sv
// Purpose: Self-checking bench for the alert qualify and beta register bank.
// Assumes: Bus timeout shortened to 50 cycles.
// Notes: Every test starts from a fresh reset.
`timescale 1ns/1ps
`include "taq_cfg.svh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
    logic mclk = 0, reset_n = 0, clk_en = 1, conv_done = 0, alert_comparator_mode = 0;
    logic vsense_alert = 0, vsource_alert = 0, peak_alert = 0, bus_clock_line = 1;
    logic [3:1] diode_fault = 0;
    logic [3:0] temp_high = 0, temp_low = 0, temp_crit = 0;
    logic [3:0] beta_detected_1 = 0, beta_detected_2 = 0;
    wire reg_wr, reg_rd, reg_hit, beta_autodetect_en_1, beta_autodetect_en_2;
    wire bus_timeout_rst, alert_out_n, thermal_out_n;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [3:0] beta_comp_code_1, beta_comp_code_2;
    int fails = 0, n_tests = 0, seen;
    logic [7:0] d;
    logic [7:0] ads [6] = '{8'h1B, 8'h1F, 8'h22, 8'h25, 8'h26, 8'h23};
    logic [7:0] rst [6] = '{8'h00, 8'h00, 8'h70, 8'h10, 8'h10, 8'h00};
    taq_regs #(.TIMEOUT_CYC(50)) taq_regs_i (.mclk, .reset_n, .clk_en, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .conv_done, .diode_fault, .temp_high,
        .temp_low, .temp_crit, .alert_comparator_mode, .vsense_alert, .vsource_alert,
        .peak_alert, .beta_detected_1, .beta_detected_2, .beta_comp_code_1,
        .beta_comp_code_2, .beta_autodetect_en_1, .beta_autodetect_en_2, .bus_clock_line,
        .bus_timeout_rst, .alert_out_n, .thermal_out_n);
    taq_host_model taq_host_model_i (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .reg_hit);
    always #4 mclk = ~mclk;
    task automatic do_reset();
        reset_n = 0;
        alert_comparator_mode = 0;
        {vsense_alert, vsource_alert, peak_alert} = 3'h0;
        bus_clock_line = 1;
        repeat (16) @(posedge mclk);
        #1 reset_n = 1;
        repeat (4) @(posedge mclk);
        #1;
    endtask
    // The alert and thermal pins are registered, so results are judged three cycles later.
    task automatic conv(input logic [3:1] f, input logic [3:0] h, l, c);
        @(posedge mclk) #1;
        conv_done = 1;
        {diode_fault, temp_high, temp_low, temp_crit} = {f, h, l, c};
        @(posedge mclk) #1;
        conv_done = 0;
        {diode_fault, temp_high, temp_low, temp_crit} = '0;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic wait3();
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic t_reset();
        do_reset();
        taq_host_model_i.wr(8'h23, 8'hFF);
        for (int i = 0; i < 6; i++) begin
            taq_host_model_i.rd(ads[i], d);
            `CHK(d, rst[i])
            `CHK(taq_host_model_i.last_hit, i < 5)
        end
        $display("test reset done");
    endtask
    task automatic t_fault();
        do_reset();
        conv(3'b111, 0, 0, 0);
        `CHK(alert_out_n, 1'b0)
        conv(3'b000, 0, 0, 0);
        `CHK(alert_out_n, 1'b1)
        taq_host_model_i.rd(`TAQ_ADDR_FAULT, d);
        `CHK(d, 8'h0E)
        taq_host_model_i.rd(`TAQ_ADDR_FAULT, d);
        `CHK(d, 8'h00)
        do_reset();
        taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'h0E);
        conv(3'b101, 4'hE, 0, 0);
        `CHK(alert_out_n, 1'b1)
        taq_host_model_i.rd(`TAQ_ADDR_FAULT, d);
        `CHK(d, 8'h0A)
        $display("test fault done");
    endtask
    task automatic t_count();
        do_reset();
        taq_host_model_i.wr(`TAQ_ADDR_CONSEC, 8'h76);
        repeat (2) conv(0, 4'h2, 0, 0);
        `CHK(alert_out_n, 1'b1)
        conv(0, 4'h2, 0, 0);
        `CHK(alert_out_n, 1'b0)
        do_reset();
        taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'hFF);
        repeat (3) conv(0, 0, 0, 4'h1);
        `CHK(thermal_out_n, 1'b1)
        conv(0, 0, 0, 4'h1);
        `CHK(thermal_out_n, 1'b0)
        `CHK(alert_out_n, 1'b1)
        $display("test count done");
    endtask
    task automatic t_comp();
        do_reset();
        alert_comparator_mode = 1;
        conv(3'b111, 0, 4'hF, 0);
        `CHK(alert_out_n, 1'b1)
        conv(0, 4'h8, 0, 0);
        `CHK(alert_out_n, 1'b0)
        $display("test comparator done");
    endtask
    task automatic t_mask();
        for (int i = 0; i < 3; i++) begin
            do_reset();
            taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'h80 >> i);
            taq_host_model_i.wr(`TAQ_ADDR_CONSEC, 8'h7E);
            {vsense_alert, vsource_alert, peak_alert} = 3'b100 >> i;
            wait3();
            `CHK(alert_out_n, 1'b1)
            taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'h00);
            wait3();
            `CHK(alert_out_n, 1'b0)
        end
        do_reset();
        taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'h01);
        conv(0, 4'h1, 0, 0);
        `CHK(alert_out_n, 1'b1)
        taq_host_model_i.wr(`TAQ_ADDR_MASK, 8'h00);
        conv(0, 4'h1, 0, 0);
        `CHK(alert_out_n, 1'b0)
        $display("test mask done");
    endtask
    task automatic t_beta();
        do_reset();
        {beta_detected_1, beta_detected_2} = 8'h5A;
        conv(0, 0, 0, 0);
        taq_host_model_i.rd(`TAQ_ADDR_BETA2, d);
        `CHK(d, 8'h1A)
        taq_host_model_i.wr(`TAQ_ADDR_BETA1, 8'h13);
        taq_host_model_i.rd(`TAQ_ADDR_BETA1, d);
        `CHK(d, 8'h15)
        taq_host_model_i.manual_beta(`TAQ_ADDR_BETA1, 4'h3);
        beta_detected_1 = 4'h9;
        conv(0, 0, 0, 0);
        taq_host_model_i.rd(`TAQ_ADDR_BETA1, d);
        `CHK(d, 8'h03)
        `CHK(beta_comp_code_1, 4'h3)
        `CHK(beta_autodetect_en_1, 1'b0)
        taq_host_model_i.manual_beta(`TAQ_ADDR_BETA2, `TAQ_BETA_OFF);
        `CHK({beta_autodetect_en_2, beta_comp_code_2}, 5'h0F)
        $display("test beta done");
    endtask
    task automatic t_timeout();
        for (int en = 0; en < 2; en++) begin
            do_reset();
            if (en == 1) taq_host_model_i.wr(`TAQ_ADDR_CONSEC, 8'hF0);
            bus_clock_line = 0;
            seen = 0;
            repeat (80) begin
                @(posedge mclk) #1;
                if (bus_timeout_rst === 1'b1) seen++;
            end
            `CHK(seen, en)
        end
        $display("test timeout done");
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        t_reset();
        t_fault();
        t_count();
        t_comp();
        t_mask();
        t_beta();
        t_timeout();
        test_done();
    end
    initial begin
        #300000;
        fails++;
        test_done();
    end
endmodule
